// ==== logic/ess_frame_qualify.sv ====
`timescale 1ns/100ps
`default_nettype none

module ess_frame_qualify (
  // frame outcome
  input wire logic valid_in,
  input wire logic is_tx_in,
  input wire logic [ess_pkg::LEN_W-1:0] len_in,
  input wire logic [ess_pkg::LEN_W-1:0] max_len_in,
  input wire logic late_coll_in,
  input wire logic excess_coll_in,
  input wire logic underrun_in,
  input wire logic carrier_err_in,
  input wire logic coll_retry_in,
  // bucket hits
  output logic [ess_pkg::NUM_BUCKETS-1:0] hit_out
);
  import ess_pkg::*;

  logic base_ok;
  logic carrier_ok;
  logic carrier_ok_64;

  always_comb begin
    // a retry attempt is not a frame outcome, only its bytes count
    base_ok = valid_in && !coll_retry_in && !late_coll_in && !excess_coll_in;
    carrier_ok = !carrier_err_in;
    carrier_ok_64 = !carrier_err_in || is_tx_in; // R2
    hit_out = '0;
    hit_out[BKT_64] = base_ok && !underrun_in && carrier_ok_64 && (len_in == LEN_64); // R1 R3
    hit_out[BKT_65_127] = base_ok && carrier_ok && ess_in_range(len_in, LEN_65, LEN_127); // R4 R9
    hit_out[BKT_128_255] = base_ok && carrier_ok && ess_in_range(len_in, LEN_128, LEN_255); // R5 R9
    hit_out[BKT_256_511] = base_ok && carrier_ok && ess_in_range(len_in, LEN_256, LEN_511); // R6 R9
    hit_out[BKT_512_1023] = base_ok && !underrun_in && carrier_ok
                            && ess_in_range(len_in, LEN_512, LEN_1023); // R7 R3
    hit_out[BKT_1024_MAX] = base_ok && carrier_ok && ess_in_range(len_in, LEN_1024, max_len_in); // R8 R9
  end

endmodule : ess_frame_qualify

`default_nettype wire

// ==== logic/ess_pkg.sv ====
//==============================================================================
// Summary of operation
// R1: count exact 64-byte frames, rx or tx, free of late/excess collision, underrun, carrier.
// R2: tx frame cut by carrier loss at exactly 64 bytes still counts as 64.
// R3: 64 and 512-1023 buckets ignore crc, alignment, code and overrun errors.
// R4: count 65-127 byte frames, rx or tx, free of late/excess collision and carrier errors.
// R5: count qualifying 128-255 byte frames in their own bucket.
// R6: count qualifying 256-511 byte frames in their own bucket.
// R7: count qualifying 512-1023 byte frames in their own bucket.
// R8: count qualifying frames from 1024 up to max receive length in top bucket.
// R9: 65-127, 128-255, 256-511 and top buckets ignore underrun, overrun and rx errors.
// R10: byte counter adds every frame, any address match, any length.
// R11: byte counter adds bytes sent before carrier loss.
// R12: byte counter adds bytes before each collision, again on every retry.
// R13: half duplex rx bytes are added up to the flow control jam, jam excluded.
// R14: byte counter ignores alignment, crc, code, overrun and underrun errors.
// R15: count matching rx frames refused at start for full fifo or no buffer.
// R16: count matching rx frames that lost reception mid-frame for lack of resources.
// R17: count matching rx frames dropped for a zero head descriptor pointer.
// R18: overrun counters ignore crc, alignment and code errors.
// R19: frame counters add one, byte counter adds length, at frame outcome.
`default_nettype none

package ess_pkg;

  //============================================================================
  // widths
  localparam int LEN_W = 16;
  localparam int CNT_W = 32;
  localparam int NUM_BUCKETS = 6;

  //============================================================================
  // bucket indices
  localparam int BKT_64 = 0;
  localparam int BKT_65_127 = 1;
  localparam int BKT_128_255 = 2;
  localparam int BKT_256_511 = 3;
  localparam int BKT_512_1023 = 4;
  localparam int BKT_1024_MAX = 5;

  //============================================================================
  // bucket bounds in bytes
  localparam logic [LEN_W-1:0] LEN_64 = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_65 = 16'h0041;
  localparam logic [LEN_W-1:0] LEN_127 = 16'h007F;
  localparam logic [LEN_W-1:0] LEN_128 = 16'h0080;
  localparam logic [LEN_W-1:0] LEN_255 = 16'h00FF;
  localparam logic [LEN_W-1:0] LEN_256 = 16'h0100;
  localparam logic [LEN_W-1:0] LEN_511 = 16'h01FF;
  localparam logic [LEN_W-1:0] LEN_512 = 16'h0200;
  localparam logic [LEN_W-1:0] LEN_1023 = 16'h03FF;
  localparam logic [LEN_W-1:0] LEN_1024 = 16'h0400;

  //============================================================================
  // reset values and pipeline depth
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam int EVENT_TO_COUNT_CYCLES = 2;

  function automatic logic ess_in_range(input logic [LEN_W-1:0] len, input logic [LEN_W-1:0] lo,
                                        input logic [LEN_W-1:0] hi);
    ess_in_range = (len >= lo) && (len <= hi);
  endfunction : ess_in_range

endpackage : ess_pkg

`default_nettype wire

// ==== logic/ess_stat_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module ess_stat_counter #(
  parameter int CNT_W = 32,
  parameter int ADD_W = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // increment
  input wire logic add_en_in,
  input wire logic [ADD_W-1:0] add_val_in,
  // count
  output logic [CNT_W-1:0] count_out
);
  import ess_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // wraps silently at full scale, software reads deltas
  always_comb begin
    count_nxt = count_r;
    if (srst_in) begin
      count_nxt = CNT_W'(CNT_RESET);
    end else if (add_en_in) begin
      count_nxt = count_r + CNT_W'(add_val_in);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    count_r <= count_nxt;
  end

  assign count_out = count_r;

endmodule : ess_stat_counter

`default_nettype wire

// ==== logic/ess_stats_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module ess_stats_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // configuration
  input wire logic [ess_pkg::LEN_W-1:0] max_rx_frame_length_in,
  // frame outcome event from the mac paths
  input wire logic frame_done_in,
  input wire logic frame_is_tx_in,
  input wire logic [ess_pkg::LEN_W-1:0] frame_len_in,
  input wire logic addr_match_in,
  input wire logic late_coll_in,
  input wire logic excess_coll_in,
  input wire logic underrun_in,
  input wire logic carrier_err_in,
  input wire logic coll_retry_in,
  input wire logic sof_overrun_in,
  input wire logic mof_overrun_in,
  input wire logic dma_overrun_in,
  // length histogram
  output logic [ess_pkg::CNT_W-1:0] bucket_exact_64_count_out,
  output logic [ess_pkg::CNT_W-1:0] bucket_65_to_127_count_out,
  output logic [ess_pkg::CNT_W-1:0] bucket_128_to_255_count_out,
  output logic [ess_pkg::CNT_W-1:0] bucket_256_to_511_count_out,
  output logic [ess_pkg::CNT_W-1:0] bucket_512_to_1023_count_out,
  output logic [ess_pkg::CNT_W-1:0] bucket_1024_to_max_count_out,
  // utilization and overruns
  output logic [ess_pkg::CNT_W-1:0] network_byte_count_out,
  output logic [ess_pkg::CNT_W-1:0] rx_start_overrun_count_out,
  output logic [ess_pkg::CNT_W-1:0] rx_middle_overrun_count_out,
  output logic [ess_pkg::CNT_W-1:0] rx_descriptor_overrun_count_out
);
  import ess_pkg::*;

  //============================================================================
  // event capture stage
  // one register stage keeps the wide length compares off the input pins
  logic ev_valid_r, ev_valid_nxt;
  logic ev_tx_r, ev_tx_nxt;
  logic [LEN_W-1:0] ev_len_r, ev_len_nxt;
  logic ev_match_r, ev_match_nxt;
  logic ev_late_r, ev_late_nxt;
  logic ev_excess_r, ev_excess_nxt;
  logic ev_under_r, ev_under_nxt;
  logic ev_carrier_r, ev_carrier_nxt;
  logic ev_retry_r, ev_retry_nxt;
  logic ev_sof_r, ev_sof_nxt;
  logic ev_mof_r, ev_mof_nxt;
  logic ev_dma_r, ev_dma_nxt;
  logic [LEN_W-1:0] max_len_r, max_len_nxt;

  always_comb begin
    ev_valid_nxt = frame_done_in;
    ev_tx_nxt = frame_is_tx_in;
    ev_len_nxt = frame_len_in;
    ev_match_nxt = addr_match_in;
    ev_late_nxt = late_coll_in;
    ev_excess_nxt = excess_coll_in;
    ev_under_nxt = underrun_in;
    ev_carrier_nxt = carrier_err_in;
    ev_retry_nxt = coll_retry_in;
    ev_sof_nxt = sof_overrun_in;
    ev_mof_nxt = mof_overrun_in;
    ev_dma_nxt = dma_overrun_in;
    max_len_nxt = max_rx_frame_length_in;
    if (srst_in) begin
      ev_valid_nxt = 1'b0;
      ev_tx_nxt = 1'b0;
      ev_len_nxt = '0;
      ev_match_nxt = 1'b0;
      ev_late_nxt = 1'b0;
      ev_excess_nxt = 1'b0;
      ev_under_nxt = 1'b0;
      ev_carrier_nxt = 1'b0;
      ev_retry_nxt = 1'b0;
      ev_sof_nxt = 1'b0;
      ev_mof_nxt = 1'b0;
      ev_dma_nxt = 1'b0;
      max_len_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    ev_valid_r <= ev_valid_nxt;
    ev_tx_r <= ev_tx_nxt;
    ev_len_r <= ev_len_nxt;
    ev_match_r <= ev_match_nxt;
    ev_late_r <= ev_late_nxt;
    ev_excess_r <= ev_excess_nxt;
    ev_under_r <= ev_under_nxt;
    ev_carrier_r <= ev_carrier_nxt;
    ev_retry_r <= ev_retry_nxt;
    ev_sof_r <= ev_sof_nxt;
    ev_mof_r <= ev_mof_nxt;
    ev_dma_r <= ev_dma_nxt;
    max_len_r <= max_len_nxt;
  end

  //============================================================================
  // length histogram
  logic [NUM_BUCKETS-1:0] bucket_hit;
  logic [CNT_W-1:0] bucket_cnt [NUM_BUCKETS];

  ess_frame_qualify u_qualify (
    .valid_in(ev_valid_r),
    .is_tx_in(ev_tx_r),
    .len_in(ev_len_r),
    .max_len_in(max_len_r),
    .late_coll_in(ev_late_r),
    .excess_coll_in(ev_excess_r),
    .underrun_in(ev_under_r),
    .carrier_err_in(ev_carrier_r),
    .coll_retry_in(ev_retry_r),
    .hit_out(bucket_hit)
  );

  for (genvar b = 0; b < NUM_BUCKETS; b++) begin : g_bucket
    ess_stat_counter #(.CNT_W(CNT_W), .ADD_W(1)) u_cnt (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .add_en_in(bucket_hit[b]), // R19
      .add_val_in(1'b1),
      .count_out(bucket_cnt[b])
    );
  end

  assign bucket_exact_64_count_out = bucket_cnt[BKT_64];
  assign bucket_65_to_127_count_out = bucket_cnt[BKT_65_127];
  assign bucket_128_to_255_count_out = bucket_cnt[BKT_128_255];
  assign bucket_256_to_511_count_out = bucket_cnt[BKT_256_511];
  assign bucket_512_to_1023_count_out = bucket_cnt[BKT_512_1023];
  assign bucket_1024_to_max_count_out = bucket_cnt[BKT_1024_MAX];

  //============================================================================
  // network bytes
  // every event adds its wire length: retries, carrier loss and jam-cut rx included,
  // the partner reports rx length up to the jam so the jam itself is never added
  ess_stat_counter #(.CNT_W(CNT_W), .ADD_W(LEN_W)) u_net_bytes (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .add_en_in(ev_valid_r), // R10 R11 R12 R13 R14
    .add_val_in(ev_len_r),
    .count_out(network_byte_count_out)
  );

  //============================================================================
  // receive overruns
  // error flags for crc, alignment and code are not inputs here, so they cannot gate
  logic ovr_qual;
  logic sof_hit;
  logic mof_hit;
  logic dma_hit;

  always_comb begin
    ovr_qual = ev_valid_r && !ev_tx_r && ev_match_r; // R18
    sof_hit = ovr_qual && ev_sof_r; // R15
    mof_hit = ovr_qual && ev_mof_r && !ev_sof_r; // R16
    dma_hit = ovr_qual && ev_dma_r; // R17
  end

  ess_stat_counter #(.CNT_W(CNT_W), .ADD_W(1)) u_sof_cnt (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .add_en_in(sof_hit),
    .add_val_in(1'b1),
    .count_out(rx_start_overrun_count_out)
  );

  ess_stat_counter #(.CNT_W(CNT_W), .ADD_W(1)) u_mof_cnt (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .add_en_in(mof_hit),
    .add_val_in(1'b1),
    .count_out(rx_middle_overrun_count_out)
  );

  ess_stat_counter #(.CNT_W(CNT_W), .ADD_W(1)) u_dma_cnt (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .add_en_in(dma_hit),
    .add_val_in(1'b1),
    .count_out(rx_descriptor_overrun_count_out)
  );

  //============================================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_final_clean;
    frame_done_in && !coll_retry_in && !late_coll_in && !excess_coll_in;
  endsequence

  sequence s_rx_64;
    s_final_clean ##0 (!frame_is_tx_in && !underrun_in && !carrier_err_in && frame_len_in == 16'h0040);
  endsequence

  sequence s_tx_carrier_64;
    s_final_clean ##0 (frame_is_tx_in && !underrun_in && carrier_err_in && frame_len_in == 16'h0040);
  endsequence

  chk_b64_rx_count: assert property ( // R1
    s_rx_64 |-> ##2 (bucket_exact_64_count_out == $past(bucket_exact_64_count_out) + 32'h0000_0001))
    else $error("64 byte rx frame not counted");

  chk_b64_carrier_loss: assert property ( // R2
    s_tx_carrier_64 |-> ##2 (bucket_exact_64_count_out == $past(bucket_exact_64_count_out) + 32'h0000_0001))
    else $error("64 byte tx frame with carrier loss not counted");

  chk_b64_overrun_ok: assert property ( // R3
    (s_rx_64 ##0 (sof_overrun_in || mof_overrun_in))
    |-> ##2 (bucket_exact_64_count_out != $past(bucket_exact_64_count_out)))
    else $error("overrun blocked the 64 byte bucket");

  chk_b65_range: assert property ( // R4
    (s_final_clean ##0 (!carrier_err_in && frame_len_in >= 16'h0041 && frame_len_in <= 16'h007F))
    |-> ##2 (bucket_65_to_127_count_out == $past(bucket_65_to_127_count_out) + 32'h0000_0001))
    else $error("65 to 127 byte frame not counted");

  chk_b128_range: assert property ( // R5
    (s_final_clean ##0 (!carrier_err_in && frame_len_in >= 16'h0080 && frame_len_in <= 16'h00FF))
    |-> ##2 (bucket_128_to_255_count_out == $past(bucket_128_to_255_count_out) + 32'h0000_0001))
    else $error("128 to 255 byte frame not counted");

  chk_b256_range: assert property ( // R6
    (s_final_clean ##0 (!carrier_err_in && frame_len_in >= 16'h0100 && frame_len_in <= 16'h01FF))
    |-> ##2 (bucket_256_to_511_count_out == $past(bucket_256_to_511_count_out) + 32'h0000_0001))
    else $error("256 to 511 byte frame not counted");

  chk_b512_underrun: assert property ( // R7
    (frame_done_in && underrun_in && frame_len_in >= 16'h0200 && frame_len_in <= 16'h03FF)
    |-> ##2 $stable(bucket_512_to_1023_count_out))
    else $error("underrun frame counted in 512 to 1023 bucket");

  chk_top_over_max: assert property ( // R8
    (frame_done_in && frame_len_in > max_rx_frame_length_in && frame_len_in >= 16'h0400)
    |-> ##2 $stable(bucket_1024_to_max_count_out))
    else $error("frame above maximum counted in top bucket");

  chk_b128_underrun_ok: assert property ( // R9
    (s_final_clean ##0 (underrun_in && !carrier_err_in && frame_len_in == 16'h00C8))
    |-> ##2 (bucket_128_to_255_count_out == $past(bucket_128_to_255_count_out) + 32'h0000_0001))
    else $error("underrun blocked the 128 to 255 bucket");

  chk_net_bytes_add: assert property ( // R10 R12
    frame_done_in |-> ##2 (network_byte_count_out
                           == $past(network_byte_count_out) + {16'h0000, $past(frame_len_in, 2)}))
    else $error("network bytes did not add the frame length");

  chk_net_bytes_idle: assert property ( // R19
    (!frame_done_in ##1 !frame_done_in) |=> $stable(network_byte_count_out))
    else $error("network bytes moved without an event");

  chk_sof_count: assert property ( // R15
    (frame_done_in && !frame_is_tx_in && addr_match_in && sof_overrun_in)
    |-> ##2 (rx_start_overrun_count_out == $past(rx_start_overrun_count_out) + 32'h0000_0001))
    else $error("start overrun not counted");

  chk_mof_count: assert property ( // R16
    (frame_done_in && !frame_is_tx_in && addr_match_in && mof_overrun_in && !sof_overrun_in)
    |-> ##2 (rx_middle_overrun_count_out == $past(rx_middle_overrun_count_out) + 32'h0000_0001))
    else $error("middle overrun not counted");

  chk_dma_nomatch: assert property ( // R17
    (frame_done_in && dma_overrun_in && (frame_is_tx_in || !addr_match_in))
    |-> ##2 $stable(rx_descriptor_overrun_count_out))
    else $error("descriptor overrun counted without a matching rx frame");

  sequence s_clean_carrier;
    s_final_clean ##0 !carrier_err_in;
  endsequence

  chk_b64_underrun: assert property ( // R1
    (s_final_clean ##0 (underrun_in && frame_len_in == 16'h0040))
    |-> ##2 $stable(bucket_exact_64_count_out))
    else $error("underrun frame counted in 64 byte bucket");

  chk_b64_rx_carrier: assert property ( // R2
    (frame_done_in && !frame_is_tx_in && carrier_err_in && frame_len_in == 16'h0040)
    |-> ##2 $stable(bucket_exact_64_count_out))
    else $error("rx frame with carrier error counted in 64 byte bucket");

  chk_b512_count: assert property ( // R7
    (s_clean_carrier ##0 (!underrun_in && frame_len_in >= 16'h0200 && frame_len_in <= 16'h03FF))
    |-> ##2 (bucket_512_to_1023_count_out == $past(bucket_512_to_1023_count_out) + 32'h0000_0001))
    else $error("512 to 1023 byte frame not counted");

  chk_top_count: assert property ( // R8
    (s_clean_carrier ##0 (frame_len_in >= 16'h0400 && frame_len_in <= max_rx_frame_length_in))
    |-> ##2 (bucket_1024_to_max_count_out == $past(bucket_1024_to_max_count_out) + 32'h0000_0001))
    else $error("frame of 1024 bytes up to maximum not counted");

  chk_retry_no_bucket: assert property ( // R19
    (frame_done_in && coll_retry_in)
    |-> ##2 $stable(bucket_128_to_255_count_out))
    else $error("collision retry counted as a frame");

  chk_dma_count: assert property ( // R17
    (frame_done_in && !frame_is_tx_in && addr_match_in && dma_overrun_in)
    |-> ##2 (rx_descriptor_overrun_count_out == $past(rx_descriptor_overrun_count_out) + 32'h0000_0001))
    else $error("descriptor overrun not counted");

  chk_ovr_tx_ignored: assert property ( // R15
    (frame_done_in && frame_is_tx_in)
    |-> ##2 ($stable(rx_start_overrun_count_out) && $stable(rx_middle_overrun_count_out)))
    else $error("tx event moved an overrun counter");

endmodule : ess_stats_top

`default_nettype wire

// ==== testbench/ess_mac_path_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ess_mac_path_model (
  // clock
  input wire logic sys_clk_in,
  // frame outcome event
  output logic frame_done_out,
  output logic frame_is_tx_out,
  output logic [ess_pkg::LEN_W-1:0] frame_len_out,
  // {addr, late, excess, underrun, carrier, retry, sof, mof, dma}
  output logic [8:0] flags_out
);
  import ess_pkg::*;

  initial begin
    frame_done_out = 1'b0;
    frame_is_tx_out = 1'b0;
    frame_len_out = 16'h0000;
    flags_out = 9'h000;
  end

  //============================================================================
  // one attempt per call; back-to-back calls keep the strobe high
  task automatic send(input logic tx, input logic [LEN_W-1:0] len, input logic [8:0] fl);
    @(posedge sys_clk_in);
    #1;
    frame_done_out = 1'b1;
    frame_is_tx_out = tx;
    frame_len_out = len;
    flags_out = fl;
  endtask : send

  //============================================================================
  // stale fields are inverted so a design that samples them without a strobe is caught
  task automatic idle();
    @(posedge sys_clk_in);
    #1;
    frame_done_out = 1'b0;
    frame_is_tx_out = ~frame_is_tx_out;
    frame_len_out = ~frame_len_out;
    flags_out = ~flags_out;
  endtask : idle

endmodule : ess_mac_path_model

`default_nettype wire

// ==== testbench/tb_ethernet_stats_size_overrun.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_ethernet_stats_size_overrun;
  import ess_pkg::*;

  logic sys_clk;
  logic srst;
  logic [LEN_W-1:0] max_len;
  logic done;
  logic tx;
  logic [LEN_W-1:0] len;
  logic [8:0] fl;
  logic [CNT_W-1:0] got [10];
  logic [CNT_W-1:0] exp_cnt [10];
  int num_errors;
  int check_count;

  //============================================================================
  // clock, partner and design
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ess_mac_path_model mac (
    .sys_clk_in(sys_clk),
    .frame_done_out(done),
    .frame_is_tx_out(tx),
    .frame_len_out(len),
    .flags_out(fl)
  );

  ess_stats_top DUT (
    .sys_clk_in(sys_clk),
    .srst_in(srst),
    .max_rx_frame_length_in(max_len),
    .frame_done_in(done),
    .frame_is_tx_in(tx),
    .frame_len_in(len),
    .addr_match_in(fl[8]),
    .late_coll_in(fl[7]),
    .excess_coll_in(fl[6]),
    .underrun_in(fl[5]),
    .carrier_err_in(fl[4]),
    .coll_retry_in(fl[3]),
    .sof_overrun_in(fl[2]),
    .mof_overrun_in(fl[1]),
    .dma_overrun_in(fl[0]),
    .bucket_exact_64_count_out(got[0]),
    .bucket_65_to_127_count_out(got[1]),
    .bucket_128_to_255_count_out(got[2]),
    .bucket_256_to_511_count_out(got[3]),
    .bucket_512_to_1023_count_out(got[4]),
    .bucket_1024_to_max_count_out(got[5]),
    .network_byte_count_out(got[6]),
    .rx_start_overrun_count_out(got[7]),
    .rx_middle_overrun_count_out(got[8]),
    .rx_descriptor_overrun_count_out(got[9])
  );

  //============================================================================
  // expectation model and comparison
  task automatic model(input logic t, input int n, input logic [8:0] f);
    logic am, lc, ec, ur, ce, cr, so, mo, dm, ok;
    {am, lc, ec, ur, ce, cr, so, mo, dm} = f;
    ok = !(lc || ec || cr);
    exp_cnt[6] += n;
    if (ok && n == 64 && !ur && (!ce || t)) exp_cnt[0] += 32'h0000_0001;
    if (ok && !ce && n >= 65 && n <= 127) exp_cnt[1] += 32'h0000_0001;
    if (ok && !ce && n >= 128 && n <= 255) exp_cnt[2] += 32'h0000_0001;
    if (ok && !ce && n >= 256 && n <= 511) exp_cnt[3] += 32'h0000_0001;
    if (ok && !ce && !ur && n >= 512 && n <= 1023) exp_cnt[4] += 32'h0000_0001;
    if (ok && !ce && n >= 1024 && n <= int'(max_len)) exp_cnt[5] += 32'h0000_0001;
    if (!t && am) begin
      exp_cnt[7] += so;
      exp_cnt[8] += mo && !so;
      exp_cnt[9] += dm;
    end
  endtask : model

  task automatic ev(input logic t, input int n, input logic [8:0] f);
    model(t, n, f);
    mac.send(t, n[LEN_W-1:0], f);
  endtask : ev

  task automatic cmp32(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e, input int idx);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: counter %0d got %h expected %h", $time, idx, g, e);
    end
  endtask : cmp32

  task automatic check_all();
    for (int i = 0; i < 10; i++) cmp32(got[i], exp_cnt[i], i);
  endtask : check_all

  // last event is counted two edges after its input cycle
  task automatic settle();
    mac.idle();
    @(posedge sys_clk);
    #1;
    check_all();
  endtask : settle

  task automatic clear_exp();
    for (int i = 0; i < 10; i++) exp_cnt[i] = 32'h0000_0000;
  endtask : clear_exp

  //============================================================================
  // scenarios
  task automatic t_buckets();
    int lens [13] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519};
    foreach (lens[i]) begin
      ev(1'b0, lens[i], 9'h000);
      ev(1'b1, lens[i], 9'h100);
    end
    settle();
    max_len = 16'h0400;
    ev(1'b1, 1024, 9'h000);
    ev(1'b0, 1025, 9'h000);
    settle();
    max_len = 16'h05EE;
    $display("test buckets done");
  endtask : t_buckets

  task automatic t_exclusions();
    int lens [6] = '{64, 100, 200, 300, 600, 1100};
    logic [8:0] bad [4] = '{9'h080, 9'h040, 9'h020, 9'h010};
    foreach (lens[i]) begin
      foreach (bad[j]) begin
        ev(1'b0, lens[i], bad[j]);
        ev(1'b1, lens[i], bad[j]);
      end
    end
    settle();
    $display("test exclusions done");
  endtask : t_exclusions

  task automatic t_bytes();
    ev(1'b1, 30, 9'h010);
    repeat (3) ev(1'b1, 200, 9'h008);
    ev(1'b1, 200, 9'h000);
    ev(1'b0, 40, 9'h000);
    ev(1'b0, 2000, 9'h120);
    ev(1'b0, 90, 9'h000);
    settle();
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_overruns();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      ev(1'b0, 64, {k[3], 5'h00, k[2:0]});
      ev(1'b1, 1600, {k[3], 5'h00, k[2:0]});
    end
    settle();
    $display("test overruns done");
  endtask : t_overruns

  task automatic t_midreset();
    ev(1'b0, 64, 9'h104);
    mac.idle();
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    clear_exp();
    check_all();
    ev(1'b1, 128, 9'h000);
    settle();
    $display("test mid reset done");
  endtask : t_midreset

  //============================================================================
  // run control
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    #(25 * 5000);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    srst = 1'b1;
    max_len = 16'h05EE;
    clear_exp();
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    check_all();
    $display("test reset done");
    t_buckets();
    t_exclusions();
    t_bytes();
    t_overruns();
    t_midreset();
    conclude();
  end

endmodule : tb_ethernet_stats_size_overrun

`default_nettype wire
